/* mmib_top.sv */
/*
  Multi-motor interlock and bypass sequencer with an AHB-Lite register slave.
  Assumes one AHB master with single word transfers, and a terminal input vector
  that is synchronous to hclk apart from the fault contacts, which are filtered.
*/
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`include "mmib_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module mmib_top
  import mmib_pkg::*;
#(
  parameter int unsigned FILT_CYCLES = `MMIB_FILT_CYCLES,
  parameter int          NUM_ILK     = 4
) (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  // terminals and process values
  input  wire logic [10:0] terminal_in,
  input  wire logic        expansion_fitted,
  input  wire logic [15:0] feedback,
  input  wire logic [15:0] pid_speed,
  // motor outputs
  output var  logic        relay_out_1,
  output var  logic        relay_out_2,
  output var  logic        transistor_output_a,
  output var  logic        transistor_output_b,
  output var  logic [3:0]  main_connect,
  output var  logic        main_out_enable,
  output var  logic [15:0] main_speed
);

  logic [31:0]  ctrl_ff;
  logic [15:0]  map_ff;
  logic [15:0]  fbmax_ff;
  logic [15:0]  fmax_ff;
  logic [2:0]   stage_ff;
  logic [31:0]  hrdata_ff;
  logic         hreadyout_ff;
  logic         wr_pend_ff;
  logic [7:0]   wr_addr_ff;
  logic [3:0]   motor_on_ff;
  logic [3:0]   main_connect_ff;
  logic         main_out_enable_ff;
  logic [15:0]  speed_ff;
  logic [1:0]   main_ff;
  mmib_state_t  state_ff;

  logic [NUM_ILK-1:0] ilk_raw;
  logic [NUM_ILK-1:0] ilk_filt;
  logic [3:0]         ilk_act;
  logic [3:0]         nxt_motor_on;
  logic [15:0]        nxt_speed;
  logic [1:0]         nxt_main;
  logic               main_found;
  logic [2:0]         n_want;
  logic [2:0]         n_bypass;
  logic [31:0]        rd_data;
  logic               addr_ok;

  mmib_rot_t   mode;
  logic [2:0]  first_sel;
  logic [2:0]  aux_count;
  logic        ilk_on;
  logic        bypass_on;
  logic        mode_main;

  assign mode      = mmib_rot_t'(ctrl_ff[`MMIB_MODE_LSB +: 2]);
  assign first_sel = ctrl_ff[`MMIB_FIRST_LSB +: 3];
  assign aux_count = ctrl_ff[`MMIB_COUNT_LSB +: 3];
  assign ilk_on    = (ctrl_ff[`MMIB_ILKEN_LSB +: 8] == `MMIB_ENABLE_VAL);
  assign bypass_on = (ctrl_ff[`MMIB_BYPASS_LSB +: 8] == `MMIB_ENABLE_VAL);
  assign mode_main = (mode == MMIB_ROT_MAIN);

  // terminal select; expansion terminals read as no fault when not fitted
  always_comb begin
    for (int i = 0; i < NUM_ILK; i++) begin
      logic [3:0] sel;
      sel = map_ff[4*i +: 4];
      ilk_raw[i] = 1'b0;
      if (sel < 4'(`MMIB_TERM_COUNT) && (expansion_fitted || sel < `MMIB_TERM_EXP_BASE)) begin
        ilk_raw[i] = terminal_in[sel];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_ILK; g++) begin : g_filt
      mmib_debounce #(
        .FILT_CYCLES (FILT_CYCLES)
      ) u_deb (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .raw     (ilk_raw[g]),
        .filt    (ilk_filt[g])
      );
    end
  endgenerate

  // interlock n sits on motor slot n-1: R1, R2, QA, QB; QB only counts in main mode or at count 4
  assign ilk_act = ilk_on ? {ilk_filt[3] & (mode_main | aux_count == 3'h4),
                             ilk_filt[2:0]} : 4'h0;

  // bypass staging: stage n once feedback*count reaches n*max
  always_comb begin
    logic [19:0] fb_scaled;
    logic [15:0] fb_c;
    fb_c      = (feedback > fbmax_ff) ? fbmax_ff : feedback;
    fb_scaled = 20'(fb_c) * 20'(aux_count);
    n_bypass  = 3'h0;
    for (int k = 1; k <= 4; k++) begin
      if (fbmax_ff != 16'h0000 && 3'(k) <= aux_count &&
          fb_scaled >= 20'(k) * 20'(fbmax_ff)) begin
        n_bypass = n_bypass + 3'h1;
      end
    end
    nxt_speed = pid_speed;
    if (bypass_on) begin
      nxt_speed = (fbmax_ff == 16'h0000) ? 16'h0000 :
                  16'((32'(fb_c) * 32'(fmax_ff)) / 32'(fbmax_ff));
    end
  end

  assign n_want = bypass_on ? n_bypass : stage_ff;

  // walk the start order and take the first n available motors;
  // the same walk covers skip, substitution and restore
  always_comb begin
    int pool;
    int start;
    int picked;
    int idx;
    pool   = 0;
    start  = 0;
    picked = 0;
    idx    = 0;
    nxt_motor_on = 4'h0;
    if (mode_main) begin
      pool  = 3;
      start = int'(main_ff) + 1;
    end else begin
      pool  = (aux_count == 3'h0) ? 1 : ((aux_count > 3'h4) ? 4 : int'(aux_count));
      start = (first_sel == 3'h0 || int'(first_sel) > pool) ? 0 : int'(first_sel) - 1;
    end
    for (int k = 0; k < 4; k++) begin
      idx = mode_main ? ((start + k) % 4) : ((start + k) % pool);
      if (k < pool && !ilk_act[idx] && picked < int'(n_want)) begin
        nxt_motor_on[idx] = 1'b1;
        picked = picked + 1;
      end
    end
  end

  // next healthy motor after the faulted output motor
  always_comb begin
    nxt_main   = main_ff;
    main_found = 1'b0;
    for (int k = 3; k >= 1; k--) begin
      if (!ilk_act[2'(int'(main_ff) + k)]) begin
        nxt_main   = 2'(int'(main_ff) + k);
        main_found = 1'b1;
      end
    end
  end

  // output motor handover; the faulted one drops back into the aux order
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff           <= MMIB_ST_RUN;
      main_ff            <= 2'h0;
      main_out_enable_ff <= 1'b1;
    end else if (ce) begin
      if (wr_pend_ff && wr_addr_ff == `MMIB_CTRL_OFS) begin
        main_ff <= (hwdata[`MMIB_FIRST_LSB +: 3] == 3'h0) ? 2'h0 :
                   2'(hwdata[`MMIB_FIRST_LSB +: 3] - 3'h1);
      end
      case (state_ff)
        MMIB_ST_RUN: begin
          if (mode_main && ilk_act[main_ff]) begin
            state_ff           <= MMIB_ST_BLOCK;
            main_out_enable_ff <= 1'b0;
          end
        end
        MMIB_ST_BLOCK: begin
          if (!mode_main) begin
            state_ff <= MMIB_ST_CONNECT;
          end else if (main_found) begin
            main_ff  <= nxt_main;
            state_ff <= MMIB_ST_CONNECT;
          end
        end
        MMIB_ST_CONNECT: begin
          state_ff           <= MMIB_ST_RUN;
          main_out_enable_ff <= 1'b1;
        end
        default: begin
          state_ff           <= MMIB_ST_RUN;
          main_out_enable_ff <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_on_ff     <= 4'h0;
      main_connect_ff <= 4'h0;
      speed_ff        <= 16'h0000;
    end else if (ce) begin
      motor_on_ff     <= nxt_motor_on;
      main_connect_ff <= (mode_main && state_ff == MMIB_ST_RUN && !ilk_act[main_ff]) ?
                         (4'h1 << main_ff) : 4'h0;
      speed_ff        <= nxt_speed;
    end
  end

  // AHB-Lite slave, zero wait states; read data taken in the address phase
  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

  always_comb begin
    rd_data = 32'h0000_0000;
    case (haddr[7:0])
      `MMIB_CTRL_OFS:   rd_data = ctrl_ff;
      `MMIB_MAP_OFS:    rd_data = {16'h0000, map_ff};
      `MMIB_FBMAX_OFS:  rd_data = {16'h0000, fbmax_ff};
      `MMIB_FMAX_OFS:   rd_data = {16'h0000, fmax_ff};
      `MMIB_STAGE_OFS:  rd_data = {29'h0, stage_ff};
      `MMIB_STATUS_OFS: rd_data = {18'h0, main_ff, main_out_enable_ff, state_ff,
                                   ilk_act, motor_on_ff};
      `MMIB_SPEED_OFS:  rd_data = {13'h0, n_want, speed_ff};
      default:          rd_data = 32'h0000_0000;
    endcase
    if (!addr_ok) begin
      rd_data = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
    end else if (ce) begin
      hreadyout_ff <= 1'b1;
      wr_pend_ff   <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        wr_pend_ff <= hwrite && addr_ok && (hsize == 3'h2);
        wr_addr_ff <= haddr[7:0];
        if (!hwrite) begin
          hrdata_ff <= rd_data;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff  <= `MMIB_CTRL_RST;
      map_ff   <= 16'(`MMIB_MAP_RST);
      fbmax_ff <= `MMIB_FBMAX_RST;
      fmax_ff  <= `MMIB_FMAX_RST;
      stage_ff <= `MMIB_STAGE_RST;
    end else if (ce && wr_pend_ff) begin
      case (wr_addr_ff)
        `MMIB_CTRL_OFS:  ctrl_ff  <= {8'h00, hwdata[23:0]};
        `MMIB_MAP_OFS:   map_ff   <= hwdata[15:0];
        `MMIB_FBMAX_OFS: fbmax_ff <= hwdata[15:0];
        `MMIB_FMAX_OFS:  fmax_ff  <= hwdata[15:0];
        `MMIB_STAGE_OFS: stage_ff <= hwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  assign hreadyout           = hreadyout_ff;
  assign hresp               = 1'b0;
  assign hrdata              = hrdata_ff;
  assign relay_out_1         = motor_on_ff[0];
  assign relay_out_2         = motor_on_ff[1];
  assign transistor_output_a = motor_on_ff[2];
  assign transistor_output_b = motor_on_ff[3];
  assign main_connect        = main_connect_ff;
  assign main_out_enable     = main_out_enable_ff;
  assign main_speed          = speed_ff;

  ilk_gate_a : assert property (@(posedge hclk) disable iff (!hresetn)
    !ilk_on |-> (ilk_act == 4'h0))
    else $error("interlock acted while disabled");

  fault_off_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> ((motor_on_ff & $past(ilk_act)) == 4'h0))
    else $error("faulted motor left running");

  stage_count_a : assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> ($countones(motor_on_ff) <= int'($past(n_want))))
    else $error("more auxiliaries running than demanded");

  full_stage_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && !mode_main && ilk_act == 4'h0 && aux_count == 3'h3 && n_want == 3'h3)
    |=> (motor_on_ff[2:0] == 3'h7))
    else $error("healthy auxiliaries not all restored");

  main_block_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && state_ff == MMIB_ST_RUN && mode_main && ilk_act[main_ff])
    |=> (!main_out_enable_ff && main_connect_ff == 4'h0))
    else $error("faulted output motor not blocked");

  main_swap_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && state_ff == MMIB_ST_BLOCK && mode_main && main_found)
    |=> (main_ff != $past(main_ff) && state_ff == MMIB_ST_CONNECT))
    else $error("output motor not handed to the next one");

  main_excl_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && mode_main) |=> ((motor_on_ff & (4'h1 << $past(main_ff))) == 4'h0))
    else $error("output motor also driven as auxiliary");

  bypass_max_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && bypass_on && fbmax_ff != 16'h0000 && feedback >= fbmax_ff)
    |=> (speed_ff == $past(fmax_ff)))
    else $error("maximum feedback did not give maximum speed");

  bypass_zero_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && bypass_on && feedback == 16'h0000) |=> (motor_on_ff == 4'h0))
    else $error("auxiliary started at zero feedback");

  exp_term_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (!expansion_fitted && map_ff[3:0] >= `MMIB_TERM_EXP_BASE) |-> !ilk_raw[0])
    else $error("expansion terminal used without expansion");

endmodule
`default_nettype wire

/* mmib_consts.svh */
/*
  Constants for the multi-motor interlock and bypass block: register offsets, field
  positions, reset values and the input filter time.
  Assumes a 50 MHz hclk and one 32-bit word per register.
*/
`ifndef MMIB_CONSTS_SVH
`define MMIB_CONSTS_SVH

// register byte offsets
`define MMIB_CTRL_OFS      8'h00
`define MMIB_MAP_OFS       8'h04
`define MMIB_FBMAX_OFS     8'h08
`define MMIB_FMAX_OFS      8'h0C
`define MMIB_STAGE_OFS     8'h10
`define MMIB_STATUS_OFS    8'h14
`define MMIB_SPEED_OFS     8'h18

// control register fields
`define MMIB_MODE_LSB      0
`define MMIB_FIRST_LSB     2
`define MMIB_COUNT_LSB     5
`define MMIB_ILKEN_LSB     8
`define MMIB_BYPASS_LSB    16

// reset values
`define MMIB_CTRL_RST      32'h0000_0064
`define MMIB_MAP_RST       32'h0000_3210
`define MMIB_FBMAX_RST     16'h0FFF
`define MMIB_FMAX_RST      16'h1770
`define MMIB_STAGE_RST     3'h0

// enable settings act only at exactly this value
`define MMIB_ENABLE_VAL    8'h01

// terminal inputs: base set, then expansion set
`define MMIB_TERM_COUNT    11
`define MMIB_TERM_EXP_BASE 4'h8

// contact filter time
`define MMIB_CLK_MHZ       50
`define MMIB_FILT_TIME_US  10000
`define MMIB_FILT_CYCLES   (`MMIB_FILT_TIME_US * `MMIB_CLK_MHZ)

`endif

/* mmib_pkg.sv */
/*
  Types for the multi-motor interlock and bypass block.
  Assumes the constants header is included by the modules that need numbers.
*/
`default_nettype none
package mmib_pkg;

  typedef enum logic [1:0] {
    MMIB_ROT_NONE = 2'h0,
    MMIB_ROT_AUX  = 2'h1,
    MMIB_ROT_MAIN = 2'h2
  } mmib_rot_t;

  typedef enum logic [2:0] {
    MMIB_ST_RUN     = 3'b001,
    MMIB_ST_BLOCK   = 3'b010,
    MMIB_ST_CONNECT = 3'b100
  } mmib_state_t;

endpackage
`default_nettype wire

/* mmib_debounce.sv */
/*
  Two-flop synchroniser and stability filter for one fault contact.
  Assumes the contact is a slow level; a change must stand FILT_CYCLES cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module mmib_debounce #(
  parameter int unsigned FILT_CYCLES = 500000
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  // contact
  input  wire logic raw,
  output var  logic filt
);
  localparam int CW = $clog2(FILT_CYCLES + 1);

  logic          sync1_ff;
  logic          sync2_ff;
  logic          filt_ff;
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else if (ce) begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
    end
  end

  // bounce restarts the count, so one swap per real change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= '0;
      filt_ff <= 1'b0;
    end else if (ce) begin
      if (sync2_ff == filt_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff == CW'(FILT_CYCLES - 1)) begin
        cnt_ff  <= '0;
        filt_ff <= sync2_ff;
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end

  assign filt = filt_ff;

  filt_hold_a : assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && sync2_ff == filt_ff) |=> (filt_ff == $past(filt_ff)))
    else $error("filtered contact changed without a stable input");

endmodule
`default_nettype wire

/* mmib_motor_model.sv */
/*
  Fault contacts of four motors wired onto the terminal block.
  Assumes term_map mirrors the interlock terminal map written to the device.
*/
`timescale 1ns/1ns
`default_nettype none
module mmib_motor_model (
  // bench control
  input  wire logic [3:0]  fault_cmd,
  input  wire logic [15:0] term_map,
  // terminal block
  output var  logic [10:0] terminal_in
);
  // contact closes while its motor is faulted; unused terminals stay open
  always_comb begin
    terminal_in = '0;
    for (int i = 0; i < 4; i++) begin
      if (term_map[4*i +: 4] < 4'hB) begin
        terminal_in[term_map[4*i +: 4]] = terminal_in[term_map[4*i +: 4]] | fault_cmd[i];
      end
    end
  end
endmodule
`default_nettype wire

/* test_multi_motor_interlock_bypass.sv */
/*
  Self-checking bench for the interlock and bypass sequencer.
  Assumes zero-wait AHB-Lite slave and a short contact filter in simulation.
*/
`timescale 1ns/1ns
`default_nettype none
module test_multi_motor_interlock_bypass;
  logic        hclk, hresetn, hwrite, expansion_fitted;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, q;
  logic [15:0] feedback, pid_speed, term_map;
  logic [3:0]  fault_cmd;
  wire logic        hreadyout, hresp, r1, r2, qa, qb, moe;
  wire logic [31:0] hrdata;
  wire logic [3:0]  mc;
  wire logic [15:0] main_speed;
  wire logic [10:0] terminal_in;
  wire logic [3:0]  mot = {qb, qa, r2, r1};
  wire logic [24:0] obs = {main_speed, moe, mc, mot};
  int num_errors = 0;
  int n_tests = 0;
  localparam logic [24:0] MM = 25'h00000F;
  logic [7:0]  ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h40};
  logic [31:0] rv [6] = '{32'h64, 32'h3210, 32'hFFF, 32'h1770, 32'h0, 32'h0};
  logic [15:0] fb [6] = '{16'h3FF, 16'h400, 16'h800, 16'hC00, 16'h1000, 16'h2000};
  logic [15:0] sp [6] = '{16'h5DA, 16'h5DC, 16'hBB8, 16'h1194, 16'h1770, 16'h1770};
  logic [3:0]  mo [6] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'hF};

  mmib_top #(.FILT_CYCLES(4)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .terminal_in(terminal_in), .expansion_fitted(expansion_fitted),
    .feedback(feedback), .pid_speed(pid_speed), .relay_out_1(r1), .relay_out_2(r2),
    .transistor_output_a(qa), .transistor_output_b(qb), .main_connect(mc),
    .main_out_enable(moe), .main_speed(main_speed));
  mmib_motor_model u_model (.fault_cmd(fault_cmd), .term_map(term_map),
    .terminal_in(terminal_in));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // fixed pre-wait of 30 where an input must be shown to have no effect, 2 in the bypass sweep
  task automatic settle(input logic [24:0] m, input logic [24:0] e, input int pre);
    int i;
    // first look is a falling edge, never the launching rising edge
    repeat (pre + 1) @(negedge hclk);
    for (i = 0; i < 80 && (obs & m) !== e; i++) @(negedge hclk);
    chk({7'h0, obs & m}, {7'h0, e});
    // hand back on a rising edge so the next stimulus lands there
    @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  function automatic logic [31:0] ctrl(input logic [1:0] md, input logic [2:0] fs, cn,
                                       input logic [7:0] il, by);
    return {8'h0, by, il, cn, fs, md};
  endfunction

  task summarize;
    $display("mismatches %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    summarize();
  end

  initial begin
    hresetn = 1'b0; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2; haddr = '0; hwdata = '0;
    feedback = '0; pid_speed = '0; term_map = 16'h3210; fault_cmd = '0;
    expansion_fitted = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
    chk({31'h0, hresp}, 32'h0);
    wr(8'h18, 32'hFFFF_FFFF);
    rdc(8'h18, 32'h0);
    // bypass: speed and staging follow feedback, count 4
    wr(8'h08, 32'h1000);
    wr(8'h00, ctrl(2'h0, 3'h1, 3'h4, 8'h0, 8'h1));
    for (int i = 0; i < 6; i++) begin
      feedback <= fb[i];
      settle({16'hFFFF, 9'h00F}, {sp[i], 5'h0, mo[i]}, 2);
    end
    pid_speed <= 16'h1234;
    wr(8'h00, ctrl(2'h0, 3'h1, 3'h4, 8'h0, 8'h2));
    settle({16'hFFFF, 9'h00F}, {16'h1234, 9'h0}, 0);
    feedback <= '0;
    // interlocks, aux rotation
    wr(8'h00, ctrl(2'h1, 3'h1, 3'h4, 8'h1, 8'h0));
    wr(8'h10, 32'h2);
    settle(MM, 25'h3, 0);
    fault_cmd <= 4'b0010;
    settle(MM, 25'h5, 0);
    fault_cmd <= 4'b0000;
    settle(MM, 25'h3, 0);
    fault_cmd <= 4'b0100;
    wr(8'h10, 32'h3);
    settle(MM, 25'hB, 0);
    fault_cmd <= 4'b0000;
    settle(MM, 25'h7, 0);
    wr(8'h00, ctrl(2'h1, 3'h1, 3'h4, 8'h2, 8'h0));
    fault_cmd <= 4'b0001;
    settle(MM, 25'h7, 30);
    fault_cmd <= 4'b0000;
    // let the held-over filtered fault clear before re-enabling
    repeat (10) @(posedge hclk);
    wr(8'h00, ctrl(2'h1, 3'h1, 3'h4, 8'h1, 8'h0));
    // a bounce shorter than the filter must not swap motors at any cycle
    fault_cmd <= 4'b0001;
    repeat (2) @(posedge hclk);
    fault_cmd <= 4'b0000;
    repeat (10) begin
      @(negedge hclk);
      chk({7'h0, obs & MM}, 32'h7);
    end
    @(posedge hclk);
    // interlock 1 on an expansion terminal
    wr(8'h04, 32'h3219);
    term_map  <= 16'h3219;
    fault_cmd <= 4'b0001;
    settle(MM, 25'h7, 30);
    expansion_fitted <= 1'b1;
    settle(MM, 25'hE, 0);
    fault_cmd <= 4'b0000;
    wr(8'h04, 32'h3210);
    term_map <= 16'h3210;
    wr(8'h00, ctrl(2'h1, 3'h3, 3'h4, 8'h1, 8'h0));
    wr(8'h10, 32'h2);
    settle(MM, 25'hC, 0);
    fault_cmd <= 4'b0100;
    settle(MM, 25'h9, 0);
    fault_cmd <= 4'b0000;
    wr(8'h00, ctrl(2'h1, 3'h1, 3'h3, 8'h1, 8'h0));
    wr(8'h10, 32'h3);
    fault_cmd <= 4'b1000;
    settle(MM, 25'h7, 30);
    fault_cmd <= 4'b0000;
    // main-inclusive rotation
    wr(8'h10, 32'h0);
    wr(8'h00, ctrl(2'h2, 3'h1, 3'h4, 8'h1, 8'h0));
    settle(25'h1F0, 25'h110, 0);
    fault_cmd <= 4'b0001;
    settle(25'h1F0, 25'h000, 0);
    settle(25'h1F0, 25'h120, 0);
    fault_cmd <= 4'b0000;
    wr(8'h10, 32'h3);
    settle(25'hD, 25'hD, 0);
    fault_cmd <= 4'b0100;
    settle(25'hD, 25'h9, 0);
    fault_cmd <= 4'b0000;
    settle(25'hD, 25'hD, 0);
    summarize();
  end
endmodule
`default_nettype wire
